// ### pll_clock_pkg.sv
/*
  Shared constants, configuration records and a helper function for the
  clock control block and its tick prescaler.
  Assumes every clock in the design but the slow clock, a level sampled on mclk, is a one-cycle tick on mclk.

*/
package pll_clock_pkg;

  localparam int unsigned DIV_W       = 8;
  localparam int unsigned MUL_W       = 11;
  localparam int unsigned SETTLE_W    = 6;
  localparam int unsigned FREQ_W      = 16;
  localparam int unsigned CALIB_W     = 24;
  localparam int unsigned PLL_ACC_W   = 13;

  localparam logic [1:0]  SRC_SLOW    = 2'h0;
  localparam logic [1:0]  SRC_MAIN    = 2'h1;
  localparam logic [1:0]  SRC_PLL     = 2'h2;
  localparam logic [1:0]  SRC_MASTER  = 2'h3;

  localparam logic [2:0]  PRESCALER_FIELD_DIV3   = 3'h7;
  localparam logic [3:0]  FREQ_LAST_FALL = 4'hf;
  localparam logic [CALIB_W-1:0] TIMER_CALIBRATION = 24'h001770;
  localparam logic [PLL_ACC_W-1:0] PLL_ACC_CAP = 13'h0fff;

  localparam logic                 MCK_READY_RESET  = 1'h1;
  localparam logic                 PCK_READY_RESET  = 1'h1;

  typedef struct packed {
    logic [SETTLE_W-1:0] settle;
    logic [MUL_W-1:0]    mul;
    logic [DIV_W-1:0]    div;
  } pll_cfg_t;

  typedef struct packed {
    logic       half;
    logic [2:0] prescaler_field;
    logic [1:0] src;
  } mck_cfg_t;

  typedef struct packed {
    logic [2:0] prescaler_field;
    logic [1:0] src;
  } pck_cfg_t;

  localparam pll_cfg_t PLL_CFG_RESET = '{settle: 6'h00, mul: 11'h000, div: 8'h00};
  localparam mck_cfg_t MCK_CFG_RESET = '{half: 1'h0, prescaler_field: 3'h0, src: SRC_MAIN};
  localparam pck_cfg_t PCK_CFG_RESET = '{prescaler_field: 3'h0, src: SRC_SLOW};

  // Terminal count of the prescaler: divide by 2**prescaler_field, or for PRESCALER_FIELD_DIV3 by 3 when allow3 is set and by 64 otherwise.
  function automatic logic [5:0] prescaler_field_last(input logic [2:0] prescaler_field, input logic allow3);
    if (allow3 && prescaler_field == PRESCALER_FIELD_DIV3) begin
      prescaler_field_last = 6'h02;
    end else if (prescaler_field == PRESCALER_FIELD_DIV3) begin
      prescaler_field_last = 6'h3f;
    end else begin
      prescaler_field_last = 6'((7'h01 << prescaler_field) - 7'h01);
    end
  endfunction

endpackage

// ### clock_prescaler.sv
/*
  Tick prescaler: passes one of every N source ticks, N a power of two up
  to 64 or, where allowed, three.
  Assumes source ticks are one-cycle pulses on mclk.
*/
`timescale 1ns/10ps
`default_nettype none
module clock_prescaler #(
  parameter bit ALLOW_DIV3 = 1'b1
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       restart,
  input  wire logic       tick_in,
  input  wire logic [2:0] prescaler_field,
  output logic            tick_out
);

  logic [5:0] count_reg;
  logic [5:0] last;

  assign last = pll_clock_pkg::prescaler_field_last(prescaler_field, ALLOW_DIV3);

  // A restart realigns the phase so the new ratio is exact from its first tick.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_reg <= 6'h00;
      tick_out  <= 1'b0;
    end else if (restart) begin
      count_reg <= 6'h00;
      tick_out  <= 1'b0;
    end else begin
      tick_out <= tick_in && (count_reg >= last);
      if (tick_in) begin
        count_reg <= (count_reg >= last) ? 6'h00 : 6'(count_reg + 6'h01);
      end
    end
  end

  a_prescale_ratio: assert property (@(posedge mclk) disable iff (rst)
    tick_out |-> $past(tick_in) && $past(count_reg) >= $past(last) && count_reg == 6'h00)
    else $error("prescaler tick without a wrapping count");

endmodule // clock_prescaler
`default_nettype wire

// ### pll_master_clock_control.sv
/*
  Clock control: main clock frequency counter, divider and PLL with lock
  countdown, master clock selector, processor sleep gating, peripheral clock
  gates and three programmable clock outputs.
  Assumes every clock but the slow clock arrives or leaves as a one-cycle tick
  on mclk, that the slow clock is a level sampled on mclk, and that configuration arrives as
  write strobes with data from a register block outside.
*/
`timescale 1ns/10ps
`default_nettype none
module pll_master_clock_control #(
  parameter int unsigned PERIPH_COUNT = 32,
  parameter int unsigned PCK_COUNT    = 3
) (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic                        slow_clock,
  input  wire logic                        main_clock_tick,
  input  wire logic                        main_osc_stable,
  input  wire logic                        main_select_change,
  output logic                             freq_count_ready,
  output logic [pll_clock_pkg::FREQ_W-1:0] freq_count_value,
  input  wire logic                        pll_cfg_write,
  input  wire pll_clock_pkg::pll_cfg_t     pll_cfg_in,
  output pll_clock_pkg::pll_cfg_t          pll_config_register,
  output logic                             pll_ready_flag,
  output logic                             pll_clock_tick,
  input  wire logic                        mck_cfg_write,
  input  wire pll_clock_pkg::mck_cfg_t     mck_cfg_in,
  output pll_clock_pkg::mck_cfg_t          master_clock_config,
  output logic                             master_clock_ready,
  output logic                             master_clock_tick,
  input  wire logic                        wait_interrupt_instruction,
  input  wire logic                        wait_event_instruction,
  input  wire logic                        low_power_select,
  input  wire logic                        instr_complete,
  input  wire logic                        wake_interrupt,
  output logic                             cpu_sleeping,
  output logic                             cpu_clock_tick,
  output logic                             free_running_cpu_clock,
  output logic [pll_clock_pkg::CALIB_W-1:0] timer_calibration,
  input  wire logic [PERIPH_COUNT-1:0]     periph_clock_enable,
  input  wire logic [PERIPH_COUNT-1:0]     periph_clock_disable,
  output logic [PERIPH_COUNT-1:0]          periph_clock_status,
  output logic [PERIPH_COUNT-1:0]          periph_clock_tick,
  input  wire logic [PCK_COUNT-1:0]        system_clock_enable,
  input  wire logic [PCK_COUNT-1:0]        system_clock_disable,
  output logic [PCK_COUNT-1:0]             system_clock_status,
  input  wire logic [PCK_COUNT-1:0]        pck_cfg_write,
  input  wire pll_clock_pkg::pck_cfg_t     pck_cfg_in,
  output pll_clock_pkg::pck_cfg_t [PCK_COUNT-1:0] output_clock_config,
  output logic [PCK_COUNT-1:0]             pck_ready,
  output logic [PCK_COUNT-1:0]             programmable_clock_out
);

  if (PCK_COUNT < 1 || PCK_COUNT > 8) begin : g_bad_pck
    $error("PCK_COUNT must lie between 1 and 8");
  end
  if (PERIPH_COUNT < 1 || PERIPH_COUNT > 64) begin : g_bad_periph
    $error("PERIPH_COUNT must lie between 1 and 64");
  end

  function automatic logic pick_tick(input logic [1:0] src, input logic t_slow,
                                     input logic t_main, input logic t_pll,
                                     input logic t_mck);
    case (src)
      pll_clock_pkg::SRC_SLOW: pick_tick = t_slow;
      pll_clock_pkg::SRC_MAIN: pick_tick = t_main;
      pll_clock_pkg::SRC_PLL:  pick_tick = t_pll;
      default:                 pick_tick = t_mck;
    endcase
  endfunction

  // Slow clock edges.
  logic slow_prev_reg;
  logic slow_rise;
  logic slow_fall;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      slow_prev_reg <= 1'b0;
    end else begin
      slow_prev_reg <= slow_clock;
    end
  end
  assign slow_rise = slow_clock && !slow_prev_reg;
  assign slow_fall = !slow_clock && slow_prev_reg;

  // Main clock frequency counter.
  typedef enum logic [1:0] {
    FC_IDLE  = 2'b00,
    FC_ARM   = 2'b01,
    FC_COUNT = 2'b10,
    FC_DONE  = 2'b11
  } fc_state_t;

  fc_state_t fc_state_reg;
  logic      stable_prev_reg;
  logic      fc_start;
  logic [3:0] fall_cnt_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stable_prev_reg <= 1'b0;
    end else begin
      stable_prev_reg <= main_osc_stable;
    end
  end
  assign fc_start = (main_osc_stable && !stable_prev_reg) || main_select_change;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fc_state_reg     <= FC_IDLE;
      fall_cnt_reg     <= 4'h0;
      freq_count_value <= '0;
      freq_count_ready <= 1'b0;
    end else if (fc_start) begin
      fc_state_reg     <= FC_ARM;
      freq_count_ready <= 1'b0;
    end else begin
      case (fc_state_reg)
        FC_ARM: begin
          if (slow_rise) begin
            fc_state_reg     <= FC_COUNT;
            fall_cnt_reg     <= 4'h0;
            freq_count_value <= '0;
          end
        end
        FC_COUNT: begin
          if (main_clock_tick && !(&freq_count_value)) begin
            freq_count_value <= freq_count_value + 1'b1;
          end
          if (slow_fall) begin
            fall_cnt_reg <= 4'(fall_cnt_reg + 4'h1);
            if (fall_cnt_reg == pll_clock_pkg::FREQ_LAST_FALL) begin
              fc_state_reg     <= FC_DONE;
              freq_count_ready <= 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  sequence s_arm_rise;
    fc_state_reg == FC_ARM && slow_rise && !fc_start;
  endsequence

  a_freq_clear_start: assert property (@(posedge mclk) disable iff (rst)
    s_arm_rise |=> fc_state_reg == FC_COUNT && freq_count_value == '0)
    else $error("frequency counter did not clear and start on slow rise");

  a_freq_stop_sixteen: assert property (@(posedge mclk) disable iff (rst)
    fc_state_reg == FC_COUNT && slow_fall && !fc_start && fall_cnt_reg == 4'hf
    |=> freq_count_ready && fc_state_reg == FC_DONE ##1 $stable(freq_count_value))
    else $error("frequency counter did not stop on the sixteenth slow fall");

  // Divider and PLL: the output is a tick stream at (mul+1)/div of the
  // main clock. Credits are spent one tick per mclk, so the PLL rate is
  // capped at mclk; the cap on the credit store bounds the backlog.
  pll_clock_pkg::pll_cfg_t pll_cfg_reg;
  logic [pll_clock_pkg::PLL_ACC_W-1:0] pll_acc_reg;
  logic [pll_clock_pkg::PLL_ACC_W-1:0] pll_acc_next;
  logic [pll_clock_pkg::SETTLE_W-1:0]  settle_cnt_reg;
  logic pll_active;
  logic pll_emit;
  logic pll_changed;
  logic settle_busy_reg;
  logic pll_half_phase_reg;
  logic pll_src_tick;

  assign pll_active = (pll_cfg_reg.div != '0) && (pll_cfg_reg.mul != '0);
  assign pll_emit   = pll_active && (pll_acc_reg >= {5'h00, pll_cfg_reg.div});
  assign pll_changed = (pll_cfg_in.div != pll_cfg_reg.div) || (pll_cfg_in.mul != pll_cfg_reg.mul);
  assign pll_config_register = pll_cfg_reg;

  always_comb begin
    pll_acc_next = pll_acc_reg;
    if (pll_emit) begin
      pll_acc_next = pll_acc_next - {5'h00, pll_cfg_reg.div};
    end
    if (main_clock_tick && pll_active && pll_acc_next < pll_clock_pkg::PLL_ACC_CAP - 13'h0800) begin
      pll_acc_next = pll_acc_next + {2'h0, pll_cfg_reg.mul} + 13'h0001;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pll_cfg_reg <= pll_clock_pkg::PLL_CFG_RESET;
    end else if (pll_cfg_write) begin
      pll_cfg_reg <= pll_cfg_in;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pll_acc_reg    <= '0;
      pll_clock_tick <= 1'b0;
    end else if (!pll_active || (pll_cfg_write && pll_changed)) begin
      pll_acc_reg    <= '0;
      pll_clock_tick <= 1'b0;
    end else begin
      pll_acc_reg    <= pll_acc_next;
      pll_clock_tick <= pll_emit;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pll_ready_flag  <= 1'b0;
      settle_busy_reg <= 1'b0;
      settle_cnt_reg  <= '0;
    end else if (pll_cfg_write && pll_changed) begin
      pll_ready_flag  <= 1'b0;
      settle_busy_reg <= 1'b1;
      settle_cnt_reg  <= pll_cfg_in.settle;
    end else if (settle_busy_reg && slow_rise) begin
      if (settle_cnt_reg == '0) begin
        settle_busy_reg <= 1'b0;
        pll_ready_flag  <= pll_active;
      end else begin
        settle_cnt_reg <= settle_cnt_reg - 1'b1;
      end
    end
  end

  a_pll_off_silent: assert property (@(posedge mclk) disable iff (rst)
    (pll_cfg_reg.div == '0 || pll_cfg_reg.mul == '0) ##1 $stable(pll_cfg_reg)
    |-> !pll_clock_tick)
    else $error("pll ticks while divider or multiplier is zero");

  a_pll_lock_clear: assert property (@(posedge mclk) disable iff (rst)
    pll_cfg_write && pll_changed |=> !pll_ready_flag)
    else $error("pll lock flag not cleared on reconfiguration");

  a_pll_lock_count: assert property (@(posedge mclk) disable iff (rst)
    settle_busy_reg && slow_rise && settle_cnt_reg == '0 && !pll_cfg_write && pll_active
    |=> pll_ready_flag && !settle_busy_reg)
    else $error("pll lock not set when settle count reached zero");

  // Master clock selector and prescaler.
  pll_clock_pkg::mck_cfg_t mck_cfg_reg;
  logic mck_src_tick;
  logic mck_prescaler_field_tick;
  logic mck_pending_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pll_half_phase_reg <= 1'b0;
    end else if (pll_clock_tick) begin
      pll_half_phase_reg <= !pll_half_phase_reg;
    end
  end
  assign pll_src_tick = pll_clock_tick && (!mck_cfg_reg.half || pll_half_phase_reg);

  assign mck_src_tick = pick_tick(mck_cfg_reg.src, slow_rise, main_clock_tick,
                                  pll_src_tick, main_clock_tick);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mck_cfg_reg <= pll_clock_pkg::MCK_CFG_RESET;
    end else if (mck_cfg_write) begin
      mck_cfg_reg <= mck_cfg_in;
    end
  end

  clock_prescaler #(
    .ALLOW_DIV3 (1'b1)
  ) u_mck_prescaler_field (
    .mclk     (mclk),
    .rst      (rst),
    .restart  (mck_cfg_write),
    .tick_in  (mck_src_tick),
    .prescaler_field     (mck_cfg_reg.prescaler_field),
    .tick_out (mck_prescaler_field_tick)
  );

  // A fresh write restarts the wait, so it wins over a tick of the old setting.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      master_clock_ready <= pll_clock_pkg::MCK_READY_RESET;
      mck_pending_reg    <= 1'b0;
    end else if (mck_cfg_write) begin
      master_clock_ready <= 1'b0;
      mck_pending_reg    <= 1'b1;
    end else if (mck_pending_reg && mck_prescaler_field_tick) begin
      master_clock_ready <= 1'b1;
      mck_pending_reg    <= 1'b0;
    end
  end

  assign master_clock_config    = mck_cfg_reg;
  assign master_clock_tick      = mck_prescaler_field_tick;
  assign free_running_cpu_clock = mck_prescaler_field_tick;
  assign timer_calibration      = pll_clock_pkg::TIMER_CALIBRATION;

  a_mck_ready_clear: assert property (@(posedge mclk) disable iff (rst)
    mck_cfg_write |=> !master_clock_ready ##0 mck_pending_reg)
    else $error("master ready not cleared by a configuration write");

  // Processor sleep: the request waits for the current instruction to end.
  logic sleep_req_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sleep_req_reg <= 1'b0;
      cpu_sleeping  <= 1'b0;
    end else if (wake_interrupt) begin
      sleep_req_reg <= 1'b0;
      cpu_sleeping  <= 1'b0;
    end else begin
      if ((wait_interrupt_instruction || wait_event_instruction) && !low_power_select) begin
        sleep_req_reg <= 1'b1;
      end
      if ((sleep_req_reg || ((wait_interrupt_instruction || wait_event_instruction)
          && !low_power_select)) && instr_complete) begin
        cpu_sleeping  <= 1'b1;
        sleep_req_reg <= 1'b0;
      end
    end
  end

  // Only the processor clock is gated; bus masters on the master clock go on.
  assign cpu_clock_tick = mck_prescaler_field_tick && !cpu_sleeping;

  a_sleep_gates: assert property (@(posedge mclk) disable iff (rst)
    cpu_sleeping |-> !cpu_clock_tick ##0 (free_running_cpu_clock == master_clock_tick))
    else $error("processor clock ticks while asleep");

  a_wake_restart: assert property (@(posedge mclk) disable iff (rst)
    wake_interrupt |=> !cpu_sleeping && !sleep_req_reg)
    else $error("enabled interrupt did not wake the processor");

  a_sleep_waits: assert property (@(posedge mclk) disable iff (rst)
    !cpu_sleeping && !instr_complete |=> !cpu_sleeping)
    else $error("processor slept before its instruction completed");

  // Peripheral clocks: bit i is peripheral identifier i.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      periph_clock_status <= '0;
    end else begin
      periph_clock_status <= (periph_clock_status | periph_clock_enable)
                             & ~periph_clock_disable;
    end
  end

  // The disable strobe gates in its own cycle so the stop is immediate.
  assign periph_clock_tick = periph_clock_status & ~periph_clock_disable
                             & {PERIPH_COUNT{mck_prescaler_field_tick}};

  a_periph_stop_now: assert property (@(posedge mclk) disable iff (rst)
    (periph_clock_tick & periph_clock_disable) == '0)
    else $error("peripheral clock ticked in its disable cycle");

  a_zero_write_keep: assert property (@(posedge mclk) disable iff (rst)
    periph_clock_enable == '0 && periph_clock_disable == '0
    && system_clock_enable == '0 && system_clock_disable == '0
    |=> $stable(periph_clock_status) && $stable(system_clock_status))
    else $error("zero write changed a clock state");

  // Programmable clock outputs.
  logic [PCK_COUNT-1:0] pck_prescaler_field_tick;
  logic [PCK_COUNT-1:0] pck_pending_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      system_clock_status <= '0;
    end else begin
      system_clock_status <= (system_clock_status | system_clock_enable)
                             & ~system_clock_disable;
    end
  end

  for (genvar i = 0; i < PCK_COUNT; i++) begin : g_pck
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        output_clock_config[i] <= pll_clock_pkg::PCK_CFG_RESET;
      end else if (pck_cfg_write[i]) begin
        output_clock_config[i] <= pck_cfg_in;
      end
    end

    clock_prescaler #(
      .ALLOW_DIV3 (1'b0)
    ) u_pck_prescaler_field (
      .mclk     (mclk),
      .rst      (rst),
      .restart  (pck_cfg_write[i]),
      .tick_in  (pick_tick(output_clock_config[i].src, slow_rise, main_clock_tick,
                           pll_clock_tick, mck_prescaler_field_tick)),
      .prescaler_field     (output_clock_config[i].prescaler_field),
      .tick_out (pck_prescaler_field_tick[i])
    );

    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        pck_ready[i]       <= pll_clock_pkg::PCK_READY_RESET;
        pck_pending_reg[i] <= 1'b0;
      end else if (pck_cfg_write[i]) begin
        pck_ready[i]       <= 1'b0;
        pck_pending_reg[i] <= 1'b1;
      end else if (pck_pending_reg[i] && pck_prescaler_field_tick[i]) begin
        pck_ready[i]       <= 1'b1;
        pck_pending_reg[i] <= 1'b0;
      end
    end

    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        programmable_clock_out[i] <= 1'b0;
      end else begin
        programmable_clock_out[i] <= pck_prescaler_field_tick[i] && system_clock_status[i]
                                     && !system_clock_disable[i];
      end
    end
  end

  a_pck_enable_status: assert property (@(posedge mclk) disable iff (rst)
    system_clock_enable[0] && !system_clock_disable[0] |=> system_clock_status[0]
    ##1 (!$past(pck_prescaler_field_tick[0]) || programmable_clock_out[0] || !system_clock_status[0]
         || $past(system_clock_disable[0])))
    else $error("enabled output clock not active");

  a_pck_ready_clear: assert property (@(posedge mclk) disable iff (rst)
    pck_cfg_write[0] |=> !pck_ready[0])
    else $error("output ready not cleared by a configuration write");

endmodule // pll_master_clock_control
`default_nettype wire

// ### pll_master_clock_control_tb.sv
/* Self-checking bench for pll_master_clock_control.
   Assumes the design's package is compiled first and a 40 MHz mclk. */
`timescale 1ns/10ps
`default_nettype none
module pll_master_clock_control_tb;
  logic mclk, rst, slow_clock, main_select_change, pll_cfg_write, mck_cfg_write;
  logic wait_interrupt_instruction, wait_event_instruction, low_power_select;
  logic instr_complete, wake_interrupt, freq_count_ready, pll_ready_flag;
  logic master_clock_ready, cpu_sleeping, cpu_clock_tick, main_osc_stable;
  logic pll_clock_tick, master_clock_tick, free_running_cpu_clock;
  logic [15:0] freq_count_value;
  logic [23:0] timer_calibration;
  logic [31:0] periph_clock_enable, periph_clock_disable, periph_clock_status;
  logic [31:0] periph_clock_tick;
  logic [2:0] system_clock_enable, system_clock_disable, system_clock_status;
  logic [2:0] pck_cfg_write, pck_ready, programmable_clock_out;
  pll_clock_pkg::pll_cfg_t pll_cfg_in, pll_config_register;
  pll_clock_pkg::mck_cfg_t mck_cfg_in, master_clock_config;
  pll_clock_pkg::pck_cfg_t pck_cfg_in;
  pll_clock_pkg::pck_cfg_t [2:0] output_clock_config;
  int error_cnt = 0, tests_run = 0, n, sc = 0;
  int mck_ticks = 0, pll_ticks = 0, pck_ticks = 0, fr_ticks = 0, cpu_ticks = 0;
  int s_mck, s_pll, s_pck, s_fr, s_cpu;
  pll_master_clock_control i_pll_master_clock_control (
    .mclk, .rst, .slow_clock, .main_clock_tick(1'b1), .main_osc_stable,
    .main_select_change, .freq_count_ready, .freq_count_value, .pll_cfg_write,
    .pll_cfg_in, .pll_config_register, .pll_ready_flag, .pll_clock_tick,
    .mck_cfg_write, .mck_cfg_in, .master_clock_config, .master_clock_ready,
    .master_clock_tick, .wait_interrupt_instruction, .wait_event_instruction,
    .low_power_select, .instr_complete, .wake_interrupt, .cpu_sleeping, .cpu_clock_tick,
    .free_running_cpu_clock, .timer_calibration, .periph_clock_enable,
    .periph_clock_disable, .periph_clock_status, .periph_clock_tick,
    .system_clock_enable, .system_clock_disable, .system_clock_status,
    .pck_cfg_write, .pck_cfg_in, .output_clock_config, .pck_ready,
    .programmable_clock_out);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // The slow clock is a level with a 16-cycle period, far below mclk.
  always @(posedge mclk) #2 sc <= sc + 1;
  assign slow_clock = sc[3];
  // Tick counters sample on the falling edge, away from the launching edge.
  always @(negedge mclk) begin
    mck_ticks <= mck_ticks + master_clock_tick;
    pll_ticks <= pll_ticks + pll_clock_tick;
    pck_ticks <= pck_ticks + programmable_clock_out[0];
    fr_ticks  <= fr_ticks + free_running_cpu_clock;
    cpu_ticks <= cpu_ticks + cpu_clock_tick;
  end
  task stop_test;
    if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task step(input int k);
    repeat (k) @(posedge mclk);
    #2;
  endtask
  task bound(input int lim);
    if (n >= lim) begin
      error_cnt++;
      stop_test();
    end
  endtask
  task mark;
    {s_mck, s_pll, s_pck, s_fr, s_cpu} = {mck_ticks, pll_ticks, pck_ticks, fr_ticks, cpu_ticks};
  endtask
  task pll_set(input pll_clock_pkg::pll_cfg_t c);
    pll_cfg_in = c;
    pll_cfg_write = 1'b1;
    step(1);
    pll_cfg_write = 1'b0;
    chk(pll_ready_flag, 1'b0);
    chk(pll_config_register, c);
    mark();
  endtask
  task mck_set(input pll_clock_pkg::mck_cfg_t c);
    mck_cfg_in = c;
    mck_cfg_write = 1'b1;
    step(1);
    mck_cfg_write = 1'b0;
    chk(master_clock_ready, 1'b0);
    chk(master_clock_config, c);
    for (n = 0; n < 20 && master_clock_ready !== 1'b1; n++) step(1);
    bound(20);
  endtask
  task measure;
    step(1);
    main_select_change = 1'b0;
    chk(freq_count_ready, 1'b0);
    for (n = 0; n < 400 && freq_count_ready !== 1'b1; n++) step(1);
    bound(400);
    chk(freq_count_value > 16'h00f0 && freq_count_value < 16'h0104, 1'b1);
  endtask
  initial begin
    {rst, main_select_change, pll_cfg_write, mck_cfg_write} = 4'h8;
    {wait_interrupt_instruction, wait_event_instruction, instr_complete} = 3'h0;
    {low_power_select, wake_interrupt, main_osc_stable} = 3'h0;
    {pll_cfg_in, mck_cfg_in, pck_cfg_in, pck_cfg_write} = 39'h0;
    {periph_clock_enable, periph_clock_disable} = 64'h0;
    {system_clock_enable, system_clock_disable} = 6'h00;
    step(2);
    rst = 1'b0;
    chk(timer_calibration, 32'h1770);
    chk(periph_clock_status, 32'h0);
    chk(cpu_sleeping, 1'b0);
    periph_clock_enable = 32'h20;
    system_clock_enable = 3'h5;
    step(1);
    {periph_clock_enable, system_clock_enable} = 35'h0;
    step(1);
    chk(periph_clock_status, 32'h20);
    chk(periph_clock_tick, 32'h20);
    periph_clock_enable = 32'h21;
    periph_clock_disable = 32'h20;
    system_clock_disable = 3'h1;
    step(1);
    {periph_clock_enable, periph_clock_disable, system_clock_disable} = 67'h0;
    step(1);
    chk(periph_clock_status, 32'h1);
    chk(periph_clock_tick, 32'h1);
    chk(system_clock_status, 3'h4);
    pck_cfg_in = '{prescaler_field: 3'h2, src: pll_clock_pkg::SRC_MAIN};
    pck_cfg_write = 3'h1;
    step(1);
    pck_cfg_write = 3'h0;
    chk(pck_ready, 3'h6);
    chk(output_clock_config[0], pck_cfg_in);
    for (n = 0; n < 20 && pck_ready !== 3'h7; n++) step(1);
    bound(20);
    system_clock_enable = 3'h1;
    step(1);
    system_clock_enable = 3'h0;
    step(1);
    chk(system_clock_status, 3'h5);
    mark();
    step(8);
    chk(pck_ticks - s_pck, 2);
    mck_set('{half: 1'h0, prescaler_field: pll_clock_pkg::PRESCALER_FIELD_DIV3, src: pll_clock_pkg::SRC_MAIN});
    mark();
    step(9);
    chk(mck_ticks - s_mck, 3);
    pll_set('{settle: 6'h02, mul: 11'h001, div: 8'h04});
    step(30);
    chk(pll_ready_flag, 1'b0);
    for (n = 0; n < 24 && pll_ready_flag !== 1'b1; n++) step(1);
    bound(24);
    mck_set('{half: 1'h1, prescaler_field: 3'h0, src: pll_clock_pkg::SRC_PLL});
    mark();
    step(8);
    chk(pll_ticks - s_pll, 4);
    chk(mck_ticks - s_mck, 2);
    mck_set('{half: 1'h0, prescaler_field: pll_clock_pkg::PRESCALER_FIELD_DIV3, src: pll_clock_pkg::SRC_MAIN});
    pll_set('{settle: 6'h02, mul: 11'h001, div: 8'h00});
    step(80);
    chk(pll_ready_flag, 1'b0);
    chk(pll_ticks - s_pll, 0);
    pll_set('{settle: 6'h00, mul: 11'h000, div: 8'h04});
    step(40);
    chk(pll_ready_flag, 1'b0);
    chk(pll_ticks - s_pll, 0);
    main_select_change = 1'b1;
    measure();
    main_osc_stable = 1'b1;
    measure();
    {low_power_select, wait_interrupt_instruction} = 2'h3;
    step(1);
    {wait_interrupt_instruction, instr_complete} = 2'h1;
    step(1);
    chk(cpu_sleeping, 1'b0);
    {low_power_select, instr_complete, wait_event_instruction} = 3'h1;
    step(1);
    wait_event_instruction = 1'b0;
    step(2);
    chk(cpu_sleeping, 1'b0);
    instr_complete = 1'b1;
    step(1);
    instr_complete = 1'b0;
    chk(cpu_sleeping, 1'b1);
    mark();
    step(9);
    chk(cpu_clock_tick, 1'b0);
    chk(cpu_ticks - s_cpu, 0);
    chk(fr_ticks - s_fr, 3);
    wake_interrupt = 1'b1;
    step(1);
    wake_interrupt = 1'b0;
    chk(cpu_sleeping, 1'b0);
    {wait_interrupt_instruction, instr_complete} = 2'h3;
    step(1);
    {wait_interrupt_instruction, instr_complete} = 2'h0;
    chk(cpu_sleeping, 1'b1);
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    chk(cpu_sleeping, 1'b0);
    chk(periph_clock_status, 32'h0);
    step(2);
    chk(cpu_clock_tick, 1'b1);
    stop_test();
  end
endmodule // pll_master_clock_control_tb
`default_nettype wire
